// file: hdl/xbus_pkg.sv
package xbus_pkg;
  localparam int DATA_W     = 32;
  localparam int BE_W       = 4;
  localparam int SPACE_W    = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W     = DATA_W + BE_W;
  // reset straps on the data bus
  localparam int CFG_ARB_BIT   = 10;
  localparam int CFG_SYNC_BIT  = 11;
  localparam int CFG_WR_BIT    = 12;
  localparam int CFG_BLAST_BIT = 13;
  localparam int CFG_W         = 4;
  // link clock made by the host end
  localparam int CLK_PERIOD_NS  = 5;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // host end register port
  localparam int             RADDR_W    = 5;
  localparam logic [4:0]     REG_CTRL   = 5'h00;
  localparam logic [4:0]     REG_WDATA  = 5'h04;
  localparam logic [4:0]     REG_RDATA  = 5'h08;
  localparam logic [4:0]     REG_STATUS = 5'h0C;
  localparam logic [4:0]     REG_STRAP  = 5'h10;
  localparam int CTRL_START   = 0;
  localparam int CTRL_REG_SEL = 1;
  localparam int CTRL_WRITE   = 2;
  localparam int CTRL_LAST    = 3;
  localparam int CTRL_BE_LO   = 4;
  localparam int CTRL_BOFF    = 8;
  localparam int CTRL_W       = 9;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_OWNER     = 2;
  localparam int STRAP_DRIVE  = 4;
  localparam logic [4:0] STRAP_RESET = 5'h10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h0F0;

  typedef enum logic [1:0] {
    IO_IDLE = 2'b00, IO_REQ = 2'b01, IO_ADDR = 2'b10, IO_XFER = 2'b11
  } io_state_t;
  typedef enum logic [1:0] {
    HP_IDLE = 2'b00, HP_ACC = 2'b01, HP_DONE = 2'b10
  } hp_state_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_ARB = 3'b001, HS_STROBE = 3'b010, HS_END = 3'b011
  } hs_state_t;
endpackage

// file: hdl/xbus_if.sv
`timescale 1ns/100ps
interface xbus_if;
  logic [31:0] d_data_o, h_data_o, data;
  logic        d_data_oe_n, h_data_oe_n;
  logic [3:0]  d_be_o, h_be_o, host_byte_enable;
  logic        d_be_oe_n, h_be_oe_n;
  logic        d_as_n_o, h_as_n_o, d_as_oe_n, h_as_oe_n, host_addr_strobe_n;
  logic        h_wr_o, h_wr_oe_n, host_write_read;
  logic        d_rdy_o, d_rdy_oe_n, shared_ready;
  logic        h_blast_o, h_blast_oe_n, host_burst_last;
  logic        d_hreq_o, d_hreq_oe_n, h_hreq_o, h_hreq_oe_n, bus_hold_req;
  logic        d_hack_o, d_hack_oe_n, h_hack_o, h_hack_oe_n, bus_hold_ack;
  logic [3:0]  io_space_enable_n;
  logic        io_output_enable_n, io_read_enable_n, io_we_wait;
  logic        io_strobe_oe_n, io_we_wait_oe_n;
  logic        host_chip_select_n, host_reg_select, bus_back_off, host_sync_clock;

  // wire resolution with pulls: data and hold request/acknowledge pulled low, rest high
  assign data = !d_data_oe_n ? d_data_o : (!h_data_oe_n ? h_data_o : 32'h0);
  assign host_byte_enable = !d_be_oe_n ? d_be_o : (!h_be_oe_n ? h_be_o : 4'hF);
  assign host_addr_strobe_n = !d_as_oe_n ? d_as_n_o : (!h_as_oe_n ? h_as_n_o : 1'h1);
  assign host_write_read = !h_wr_oe_n ? h_wr_o : 1'h1;
  assign shared_ready = !d_rdy_oe_n ? d_rdy_o : 1'h1;
  assign host_burst_last = !h_blast_oe_n ? h_blast_o : 1'h1;
  assign bus_hold_req = !d_hreq_oe_n ? d_hreq_o : (!h_hreq_oe_n ? h_hreq_o : 1'h0);
  assign bus_hold_ack = !d_hack_oe_n ? d_hack_o : (!h_hack_oe_n ? h_hack_o : 1'h0);

  modport dev (
    output d_data_o, d_data_oe_n, d_be_o, d_be_oe_n, d_as_n_o, d_as_oe_n,
           d_rdy_o, d_rdy_oe_n, d_hreq_o, d_hreq_oe_n, d_hack_o, d_hack_oe_n,
           io_space_enable_n, io_output_enable_n, io_read_enable_n, io_we_wait,
           io_strobe_oe_n, io_we_wait_oe_n,
    input  data, host_byte_enable, host_addr_strobe_n, host_write_read,
           shared_ready, host_burst_last, bus_hold_req, bus_hold_ack,
           host_chip_select_n, host_reg_select, bus_back_off, host_sync_clock
  );
  modport host (
    output h_data_o, h_data_oe_n, h_be_o, h_be_oe_n, h_as_n_o, h_as_oe_n,
           h_wr_o, h_wr_oe_n, h_blast_o, h_blast_oe_n, h_hreq_o, h_hreq_oe_n,
           h_hack_o, h_hack_oe_n, host_chip_select_n, host_reg_select,
           bus_back_off, host_sync_clock,
    input  data, shared_ready, bus_hold_req, bus_hold_ack, io_we_wait
  );
endinterface

// file: hdl/xbus_fifo.sv
`timescale 1ns/100ps
module xbus_fifo #(
  parameter int WIDTH = xbus_pkg::FIFO_W,
  parameter int DEPTH = xbus_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r, rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push, pop;

  assign in_ready  = count_r != (AW+1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: hdl/xbus_device.sv
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - at most one space enable per access
// - shared pins: byte enables or address
// - register select picks address or data register
// - write/read polarity taken from reset strap
// - ready low for host, high for I/O
// - burst-last polarity taken from reset strap
// - one pin: I/O write enable or wait
// - output/read enables released when not driving
// - hold request and acknowledge exchange ownership
// - strobes ignored without chip select
// - bus master drives the address strobe
// - back-off abandons the current transfer
// - sync or async host mode from strap
// - arbitration mode from strap decides hold roles
module xbus_device #(
  parameter int FIFO_DEPTH = xbus_pkg::FIFO_DEPTH
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  xbus_if.dev                               bus,
  input  wire logic                         io_req,
  input  wire logic                         io_write,
  input  wire logic [xbus_pkg::SPACE_W-1:0] io_space,
  input  wire logic [xbus_pkg::BE_W-1:0]    io_addr,
  input  wire logic [xbus_pkg::DATA_W-1:0]  io_wdata,
  output logic                              io_ack,
  output logic                              io_abort,
  output logic [xbus_pkg::DATA_W-1:0]       io_rdata,
  output logic                              rx_valid,
  input  wire logic                         rx_ready,
  output logic [xbus_pkg::DATA_W-1:0]       rx_data,
  output logic [xbus_pkg::BE_W-1:0]         rx_be,
  input  wire logic [xbus_pkg::DATA_W-1:0]  tx_data,
  output logic                              tx_take,
  output logic [xbus_pkg::DATA_W-1:0]       host_addr,
  output logic                              burst_end,
  output logic [xbus_pkg::CFG_W-1:0]        cfg,
  output logic                              bus_owner
);
  localparam int DW = xbus_pkg::DATA_W;
  localparam int BW = xbus_pkg::BE_W;
  localparam int SW = DW + BW + 10;

  logic [SW-1:0] sync1_r, sync2_r;
  logic [DW-1:0] d_s;
  logic [BW-1:0] be_s;
  logic as_n_s, wr_s, rdy_s, blast_s, hreq_s, hack_s, cs_n_s, rsel_s, boff_s, sclk_s;
  logic sclk_d_r, step;
  logic [xbus_pkg::CFG_W-1:0] cfg_r;
  logic arb_ext, sync_mode, wr_pol, blast_pol, write_is, last_is;
  logic granted_r, hreq_r, owner, io_busy;
  xbus_pkg::io_state_t io_st_r, io_nxt;
  logic io_write_r, io_ack_r, io_abort_r;
  logic [xbus_pkg::SPACE_W-1:0] io_space_r;
  logic [BW-1:0] io_addr_r;
  logic [DW-1:0] io_wdata_r, io_rdata_r;
  xbus_pkg::hp_state_t hp_st_r;
  logic hp_rsel_r, hp_wr_r, hp_last_r, burst_end_r, tx_take_r;
  logic [BW-1:0] hp_be_r;
  logic [DW-1:0] hp_wdata_r, hp_rdata_r, addr_r;
  logic fifo_in_valid, fifo_in_ready;
  logic [xbus_pkg::FIFO_W-1:0] fifo_out;

  // every pin passes two flops; first stage feeds only the second
  always_ff @(posedge clk) begin
    sync1_r <= {bus.data, bus.host_byte_enable, bus.host_addr_strobe_n,
                bus.host_write_read, bus.shared_ready, bus.host_burst_last,
                bus.bus_hold_req, bus.bus_hold_ack, bus.host_chip_select_n,
                bus.host_reg_select, bus.bus_back_off, bus.host_sync_clock};
    sync2_r <= sync1_r;
  end
  assign {d_s, be_s, as_n_s, wr_s, rdy_s, blast_s, hreq_s, hack_s, cs_n_s,
          rsel_s, boff_s, sclk_s} = sync2_r;

  // straps follow the bus while reset is held, then stay put
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= d_s[xbus_pkg::CFG_BLAST_BIT:xbus_pkg::CFG_ARB_BIT];
    end
  end
  assign arb_ext   = cfg_r[0];
  assign sync_mode = cfg_r[1];
  assign wr_pol    = cfg_r[2];
  assign blast_pol = cfg_r[3];
  assign write_is  = wr_s ^ wr_pol;
  assign last_is   = ~(blast_s ^ blast_pol);

  // no reset: tracks the synced pin, so no false edge after release
  always_ff @(posedge clk) begin
    sclk_d_r <= sclk_s;
  end
  // synchronous host mode starts and ends host port accesses only on rising host clock edges
  assign step = !sync_mode | (sclk_s & !sclk_d_r);

  // internal arbitration: host asks, device grants when idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      granted_r <= 1'h0;
    end else if (arb_ext) begin
      granted_r <= 1'h0;
    end else if (!granted_r && hreq_s && io_st_r == xbus_pkg::IO_IDLE && !io_req) begin
      granted_r <= 1'h1;
    end else if (granted_r && !hreq_s) begin
      granted_r <= 1'h0;
    end
  end
  // external arbitration: device asks, host grants
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreq_r <= 1'h0;
    end else begin
      hreq_r <= arb_ext && io_nxt != xbus_pkg::IO_IDLE;
    end
  end
  assign owner   = arb_ext ? (hreq_r & hack_s) : !granted_r;
  assign io_busy = io_st_r == xbus_pkg::IO_ADDR || io_st_r == xbus_pkg::IO_XFER;

  always_comb begin
    io_nxt = io_st_r;
    case (io_st_r)
      xbus_pkg::IO_IDLE: begin
        if (io_req && hp_st_r == xbus_pkg::HP_IDLE) begin
          io_nxt = (arb_ext || granted_r) ? xbus_pkg::IO_REQ : xbus_pkg::IO_ADDR;
        end
      end
      xbus_pkg::IO_REQ: begin
        if (owner && hp_st_r == xbus_pkg::HP_IDLE) begin
          io_nxt = xbus_pkg::IO_ADDR;
        end
      end
      xbus_pkg::IO_ADDR: begin
        io_nxt = boff_s ? xbus_pkg::IO_IDLE : xbus_pkg::IO_XFER;
      end
      xbus_pkg::IO_XFER: begin
        if (boff_s || rdy_s) begin
          io_nxt = xbus_pkg::IO_IDLE;
        end
      end
      default: io_nxt = xbus_pkg::IO_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_st_r    <= xbus_pkg::IO_IDLE;
      io_write_r <= 1'h0;
      io_space_r <= '0;
      io_addr_r  <= '0;
      io_wdata_r <= '0;
      io_rdata_r <= '0;
      io_ack_r   <= 1'h0;
      io_abort_r <= 1'h0;
    end else begin
      io_st_r    <= io_nxt;
      io_ack_r   <= 1'h0;
      io_abort_r <= 1'h0;
      if (io_st_r == xbus_pkg::IO_IDLE && io_req) begin
        io_write_r <= io_write;
        io_space_r <= io_space;
        io_addr_r  <= io_addr;
        io_wdata_r <= io_wdata;
      end
      if (io_busy && boff_s) begin
        io_abort_r <= 1'h1;
      end else if (io_st_r == xbus_pkg::IO_XFER && rdy_s) begin
        io_ack_r <= 1'h1;
        if (!io_write_r) begin
          io_rdata_r <= d_s;
        end
      end
    end
  end

  // host port slave
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hp_st_r     <= xbus_pkg::HP_IDLE;
      hp_rsel_r   <= 1'h0;
      hp_wr_r     <= 1'h0;
      hp_last_r   <= 1'h0;
      hp_be_r     <= '0;
      hp_wdata_r  <= '0;
      hp_rdata_r  <= '0;
      addr_r      <= '0;
      burst_end_r <= 1'h0;
      tx_take_r   <= 1'h0;
    end else begin
      burst_end_r <= 1'h0;
      tx_take_r   <= 1'h0;
      case (hp_st_r)
        xbus_pkg::HP_IDLE: begin
          if (step && !owner && !cs_n_s && !as_n_s) begin
            hp_rsel_r  <= rsel_s;
            hp_wr_r    <= write_is;
            hp_last_r  <= last_is;
            hp_be_r    <= ~be_s;
            hp_wdata_r <= d_s;
            hp_st_r    <= xbus_pkg::HP_ACC;
          end
        end
        xbus_pkg::HP_ACC: begin
          if (hp_wr_r && !hp_rsel_r) begin
            addr_r  <= hp_wdata_r;
            hp_st_r <= xbus_pkg::HP_DONE;
          end else if (hp_wr_r) begin
            if (fifo_in_ready) begin
              addr_r  <= addr_r + 32'h1;
              hp_st_r <= xbus_pkg::HP_DONE;
            end
          end else begin
            hp_rdata_r <= hp_rsel_r ? tx_data : addr_r;
            tx_take_r  <= hp_rsel_r;
            if (hp_rsel_r) begin
              addr_r <= addr_r + 32'h1;
            end
            hp_st_r <= xbus_pkg::HP_DONE;
          end
        end
        xbus_pkg::HP_DONE: begin
          if (step && as_n_s) begin
            burst_end_r <= hp_last_r;
            hp_st_r     <= xbus_pkg::HP_IDLE;
          end
        end
        default: hp_st_r <= xbus_pkg::HP_IDLE;
      endcase
    end
  end

  assign fifo_in_valid = hp_st_r == xbus_pkg::HP_ACC && hp_wr_r && hp_rsel_r;

  xbus_fifo #(
    .WIDTH (xbus_pkg::FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({hp_be_r, hp_wdata_r}),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (fifo_out)
  );
  assign {rx_be, rx_data} = fifo_out;

  // pins: owned-bus strobes released whenever the host masters
  assign bus.io_strobe_oe_n    = !owner;
  assign bus.io_space_enable_n = io_busy ? ~(4'h1 << io_space_r) : 4'hF;
  assign bus.io_output_enable_n = !(io_st_r == xbus_pkg::IO_XFER && !io_write_r);
  assign bus.io_read_enable_n   = !(io_st_r == xbus_pkg::IO_XFER && !io_write_r);
  // wait is high while a data write is stuck on a full buffer
  assign bus.io_we_wait = owner ? !(io_st_r == xbus_pkg::IO_XFER && io_write_r)
                                : (hp_st_r == xbus_pkg::HP_ACC && !fifo_in_ready);
  assign bus.io_we_wait_oe_n = !(owner || hp_st_r != xbus_pkg::HP_IDLE);
  assign bus.d_be_o    = io_addr_r;
  assign bus.d_be_oe_n = !(owner && io_busy);
  assign bus.d_as_n_o  = io_st_r != xbus_pkg::IO_ADDR;
  assign bus.d_as_oe_n = !owner;
  assign bus.d_data_o  = io_busy ? io_wdata_r : hp_rdata_r;
  assign bus.d_data_oe_n = !((owner && io_busy && io_write_r) ||
                             (hp_st_r == xbus_pkg::HP_DONE && !hp_wr_r));
  assign bus.d_rdy_o    = hp_st_r != xbus_pkg::HP_DONE;
  assign bus.d_rdy_oe_n = hp_st_r == xbus_pkg::HP_IDLE;
  assign bus.d_hreq_o    = hreq_r;
  assign bus.d_hreq_oe_n = !arb_ext;
  assign bus.d_hack_o    = granted_r;
  assign bus.d_hack_oe_n = arb_ext;

  assign io_ack    = io_ack_r;
  assign io_abort  = io_abort_r;
  assign io_rdata  = io_rdata_r;
  assign tx_take   = tx_take_r;
  assign host_addr = addr_r;
  assign burst_end = burst_end_r;
  assign cfg       = cfg_r;
  assign bus_owner = owner;
endmodule

// file: hdl/xbus_host.sv
`timescale 1ns/100ps
module xbus_host #(
  parameter int LINK_HALF = xbus_pkg::LINK_HALF_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  xbus_if.host                               bus,
  input  wire logic [xbus_pkg::RADDR_W-1:0]  reg_addr,
  input  wire logic [xbus_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [xbus_pkg::DATA_W-1:0]        reg_rdata
);
  localparam int DW = xbus_pkg::DATA_W;
  localparam int CW = $clog2(LINK_HALF + 1);

  logic [DW+2:0] sync1_r, sync2_r;
  logic [DW-1:0] d_s;
  logic rdy_s, hreq_s, hack_s;
  logic [CW-1:0] div_r;
  logic sclk_r, rise, step;
  logic [xbus_pkg::CTRL_W-1:0] ctrl_r;
  logic [DW-1:0] wdata_r, rdata_r, rd_r;
  logic [4:0] strap_r;
  logic done_r, hack_r, hreq_r, owner, start;
  xbus_pkg::hs_state_t st_r;

  always_ff @(posedge clk) begin
    sync1_r <= {bus.data, bus.shared_ready, bus.bus_hold_req, bus.bus_hold_ack};
    sync2_r <= sync1_r;
  end
  assign {d_s, rdy_s, hreq_s, hack_s} = sync2_r;

  // link clock divider, free running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r  <= '0;
      sclk_r <= 1'h0;
    end else if (div_r == CW'(LINK_HALF - 1)) begin
      div_r  <= '0;
      sclk_r <= !sclk_r;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  assign rise = div_r == CW'(LINK_HALF - 1) && !sclk_r;
  assign step = !strap_r[1] | rise;

  assign start = reg_wr && reg_addr == xbus_pkg::REG_CTRL &&
                 reg_wdata[xbus_pkg::CTRL_START] && st_r == xbus_pkg::HS_IDLE;

  // external arbitration: grant the device while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hack_r <= 1'h0;
    end else if (!strap_r[0]) begin
      hack_r <= 1'h0;
    end else if (!hack_r && hreq_s && st_r == xbus_pkg::HS_IDLE && !start) begin
      hack_r <= 1'h1;
    end else if (hack_r && !hreq_s) begin
      hack_r <= 1'h0;
    end
  end
  assign owner = strap_r[0] ? !hack_r : (hreq_r & hack_s);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r    <= xbus_pkg::HS_IDLE;
      hreq_r  <= 1'h0;
      rdata_r <= '0;
      done_r  <= 1'h0;
    end else begin
      if (reg_wr && reg_addr == xbus_pkg::REG_STATUS && reg_wdata[xbus_pkg::ST_DONE]) begin
        done_r <= 1'h0;
      end
      case (st_r)
        xbus_pkg::HS_IDLE: begin
          if (start) begin
            st_r   <= xbus_pkg::HS_ARB;
            hreq_r <= !strap_r[0];
          end
        end
        xbus_pkg::HS_ARB: begin
          if (owner && step) begin
            st_r <= xbus_pkg::HS_STROBE;
          end
        end
        xbus_pkg::HS_STROBE: begin
          if (step && !rdy_s) begin
            rdata_r <= d_s;
            st_r    <= xbus_pkg::HS_END;
          end
        end
        xbus_pkg::HS_END: begin
          if (step && rdy_s) begin
            st_r   <= xbus_pkg::HS_IDLE;
            hreq_r <= 1'h0;
            done_r <= 1'h1;
          end
        end
        default: st_r <= xbus_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r  <= xbus_pkg::CTRL_RESET;
      wdata_r <= '0;
      strap_r <= xbus_pkg::STRAP_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        xbus_pkg::REG_CTRL:  ctrl_r <= reg_wdata[xbus_pkg::CTRL_W-1:0];
        xbus_pkg::REG_WDATA: wdata_r <= reg_wdata;
        xbus_pkg::REG_STRAP: strap_r <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_r <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        xbus_pkg::REG_CTRL:   rd_r <= DW'(ctrl_r);
        xbus_pkg::REG_WDATA:  rd_r <= wdata_r;
        xbus_pkg::REG_RDATA:  rd_r <= rdata_r;
        xbus_pkg::REG_STATUS: rd_r <= DW'({owner, done_r, st_r != xbus_pkg::HS_IDLE});
        xbus_pkg::REG_STRAP:  rd_r <= DW'(strap_r);
        default:              rd_r <= '0;
      endcase
    end else begin
      rd_r <= '0;
    end
  end
  assign reg_rdata = rd_r;

  assign bus.host_sync_clock    = sclk_r;
  assign bus.host_chip_select_n = st_r != xbus_pkg::HS_STROBE;
  assign bus.host_reg_select    = ctrl_r[xbus_pkg::CTRL_REG_SEL];
  assign bus.bus_back_off       = ctrl_r[xbus_pkg::CTRL_BOFF];
  assign bus.h_as_n_o   = st_r != xbus_pkg::HS_STROBE;
  assign bus.h_as_oe_n  = !owner;
  assign bus.h_wr_o     = ctrl_r[xbus_pkg::CTRL_WRITE] ^ strap_r[2];
  assign bus.h_wr_oe_n  = !owner;
  assign bus.h_blast_o  = !(ctrl_r[xbus_pkg::CTRL_LAST] ^ strap_r[3]);
  assign bus.h_blast_oe_n = !owner;
  assign bus.h_be_o     = ~ctrl_r[xbus_pkg::CTRL_BE_LO +: 4];
  assign bus.h_be_oe_n  = !owner;
  // strap pattern rides the data bus until software switches it off
  assign bus.h_data_o   = strap_r[xbus_pkg::STRAP_DRIVE] ?
                          (DW'(strap_r[3:0]) << xbus_pkg::CFG_ARB_BIT) : wdata_r;
  assign bus.h_data_oe_n = !(strap_r[xbus_pkg::STRAP_DRIVE] ||
                             (st_r == xbus_pkg::HS_STROBE && ctrl_r[xbus_pkg::CTRL_WRITE]));
  assign bus.h_hreq_o    = hreq_r;
  assign bus.h_hreq_oe_n = strap_r[0];
  assign bus.h_hack_o    = hack_r;
  assign bus.h_hack_oe_n = !strap_r[0];
endmodule

// file: verification/xbus_checker.sv
`timescale 1ns/100ps
module xbus_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] io_space_enable_n,
  input wire logic       io_strobe_oe_n,
  input wire logic       d_as_oe_n,
  input wire logic       d_as_n_o,
  input wire logic       d_be_oe_n,
  input wire logic       d_rdy_oe_n,
  input wire logic       d_rdy_o,
  input wire logic       host_addr_strobe_n,
  input wire logic       shared_ready,
  input wire logic       host_chip_select_n,
  input wire logic       bus_hold_req,
  input wire logic       bus_hold_ack,
  input wire logic       d_hack_o,
  input wire logic       d_hack_oe_n,
  input wire logic       bus_back_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ONE_SPACE: assert property (!io_strobe_oe_n |-> $onehot0(~io_space_enable_n))
    else $error("more than one space enable");
  AST_ADDR_ON_BE: assert property (!d_as_oe_n && !d_as_n_o |-> !d_be_oe_n)
    else $error("address pins not driven in address phase");
  AST_READY_STANDS: assert property (!d_rdy_oe_n && !d_rdy_o &&
    !host_addr_strobe_n |=> !shared_ready)
    else $error("host ready dropped while strobe held");
  AST_READY_CS: assert property ($fell(shared_ready) |-> !host_chip_select_n)
    else $error("host ready without chip select");
  AST_ACK_AFTER_REQ: assert property ($rose(bus_hold_ack) |-> bus_hold_req)
    else $error("hold ack without request");
  AST_ACK_RELEASE: assert property ($fell(bus_hold_req) |-> ##[1:16] !bus_hold_ack)
    else $error("hold ack kept after request dropped");
  AST_GRANT_FLOAT: assert property (!d_hack_oe_n && d_hack_o |->
    io_strobe_oe_n && d_as_oe_n && d_be_oe_n)
    else $error("device drives bus after granting it");
  AST_BACK_OFF: assert property (bus_back_off && io_space_enable_n != 4'hF |->
    ##[1:8] io_space_enable_n == 4'hF)
    else $error("transfer kept under back-off");
  cover property ($fell(shared_ready));
  cover property ($rose(bus_hold_ack));
  cover property (bus_back_off && io_space_enable_n != 4'hF);
endmodule

// file: verification/expansion_bus_pin_control_bench.sv
`timescale 1ns/100ps
module expansion_bus_pin_control_bench;
  logic        clk = 0, rst_n = 0, dev_rst_n = 0, io_req = 0, io_write = 0, rx_ready = 0, bl = 0;
  logic        reg_wr = 0, reg_rd = 0, io_ack, io_abort, rx_valid, burst_end, bus_owner, tx_take;
  logic [1:0]  io_space = 0;
  logic [3:0]  io_addr = 0, rx_be, cfg, sp, ad;
  logic [4:0]  reg_addr = 0;
  logic [31:0] io_wdata = 0, reg_wdata = 0, io_rdata, rx_data, host_addr, reg_rdata, st;
  logic [35:0] q[$];
  int          fail_count = 0, num_checks = 0, i;
  localparam logic [31:0] TXW = 32'hC3C3_5A5A;
  typedef struct {logic io; logic [8:0] c; logic [31:0] w; logic [31:0] e;} row_t;
  row_t rows[8] = '{'{1'h1, 9'h030, 32'h0, 32'h0}, '{1'h1, 9'h0A5, 32'h0, 32'h0},
    '{1'h1, 9'h0F2, 32'h0, 32'h0}, '{1'h1, 9'h007, 32'h0, 32'h0},
    '{1'h0, 9'h0F5, 32'h40, 32'h40}, '{1'h0, 9'h0F7, 32'hA5A5_0001, 32'h41},
    '{1'h0, 9'h0F3, 32'h0, 32'h42}, '{1'h0, 9'h03F, 32'h5A5A_0002, 32'h43}};
  xbus_if bus ();
  xbus_device xbus_device_inst (.clk, .rst_n(dev_rst_n), .bus(bus.dev), .io_req, .io_write,
    .io_space, .io_addr, .io_wdata, .io_ack, .io_abort, .io_rdata, .rx_valid, .rx_ready,
    .rx_data, .rx_be, .tx_data(TXW), .tx_take, .host_addr, .burst_end, .cfg, .bus_owner);
  xbus_host #(.LINK_HALF(2)) xbus_host_inst (.clk, .rst_n, .bus(bus.host), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  xbus_checker xbus_checker_inst (.clk, .rst_n(dev_rst_n),
    .io_space_enable_n(bus.io_space_enable_n), .io_strobe_oe_n(bus.io_strobe_oe_n),
    .d_as_oe_n(bus.d_as_oe_n), .d_as_n_o(bus.d_as_n_o), .d_be_oe_n(bus.d_be_oe_n),
    .d_rdy_oe_n(bus.d_rdy_oe_n), .d_rdy_o(bus.d_rdy_o), .shared_ready(bus.shared_ready),
    .host_addr_strobe_n(bus.host_addr_strobe_n), .bus_back_off(bus.bus_back_off),
    .host_chip_select_n(bus.host_chip_select_n), .bus_hold_req(bus.bus_hold_req),
    .bus_hold_ack(bus.bus_hold_ack), .d_hack_o(bus.d_hack_o), .d_hack_oe_n(bus.d_hack_oe_n));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask
  task automatic wdone();
    int n;
    st = 32'h0;
    for (n = 0; n < 60 && st[1] !== 1'b1; n++) rd(xbus_pkg::REG_STATUS);
    chk("done", 1'h1, st[1]);
    wr(xbus_pkg::REG_STATUS, 32'h2);
  endtask
  task automatic start(input logic [8:0] c, input logic [31:0] w);
    wr(xbus_pkg::REG_WDATA, w);
    wr(xbus_pkg::REG_CTRL, {23'h0, c});
    if (c[2:1] == 2'h3) q.push_back({c[7:4], w});
  endtask
  task automatic io(input logic [8:0] c);
    int n;
    sp = 4'h0;
    @(posedge clk);
    io_space <= c[1:0];
    io_write <= c[2];
    io_addr <= c[7:4];
    io_wdata <= {23'h0, c};
    io_req <= 1'b1;
    // taken at once; a level still high after ack starts a second transfer
    @(posedge clk);
    io_req <= 1'b0;
    for (n = 0; n < 40 && !io_ack && !io_abort; n++) @(negedge clk);
    chk("io ack", !c[8], io_ack);
    chk("io abort", c[8], io_abort);
    if (!c[8]) chk("space enables", 4'h1 << c[1:0], sp);
    if (!c[8]) chk("address pins", c[7:4], ad);
  endtask
  // negedge sampling keeps the monitors clear of the launch edge
  always @(negedge clk) begin
    if (!bus.io_strobe_oe_n) sp = sp | ~bus.io_space_enable_n;
    if (!bus.d_as_oe_n && !bus.d_as_n_o) ad = bus.host_byte_enable;
    if (burst_end) bl = 1'b1;
    if (rx_valid && rx_ready) chk("fifo word", q.pop_front(), {rx_be, rx_data});
  end
  task automatic test_done();
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // straps need both sync stages filled before the device lets go
    @(posedge clk);
    dev_rst_n <= 1'b1;
    wr(xbus_pkg::REG_STRAP, 32'h0);
    chk("default straps", 4'h0, cfg);
    chk("owner", 1'h1, bus_owner);
    foreach (rows[i]) begin
      if (rows[i].io) io(rows[i].c);
      else begin
        bl = 1'b0;
        start(rows[i].c, rows[i].w);
        wdone();
        chk("host address", rows[i].e, host_addr);
        chk("burst last", rows[i].c[3], bl);
        if (rows[i].c[2:1] == 2'h1) rd(xbus_pkg::REG_RDATA);
        if (rows[i].c[2:1] == 2'h1) chk("host read", TXW, st);
      end
    end
    wr(xbus_pkg::REG_CTRL, 32'h1F0);
    io(9'h111);
    wr(xbus_pkg::REG_CTRL, 32'h0F0);
    // fill the fifo with the far side stalled; last word must wait
    for (i = 0; i < 31; i++) begin
      start(9'h0F7, i);
      if (i < 30) wdone();
    end
    repeat (60) @(posedge clk);
    chk("wait pin", 1'h1, bus.io_we_wait);
    rx_ready <= 1'b1;
    wdone();
    repeat (40) @(posedge clk);
    chk("drained", 1'h0, rx_valid);
    dev_rst_n <= 1'b0;
    wr(xbus_pkg::REG_STRAP, 32'h1F);
    repeat (4) @(posedge clk);
    dev_rst_n <= 1'b1;
    // host keeps the new modes, only the strap drive goes off
    wr(xbus_pkg::REG_STRAP, 32'hF);
    chk("straps", 4'hF, cfg);
    bl = 1'b0;
    start(9'h0FB, 32'h0);
    wdone();
    chk("burst last", 1'h1, bl);
    rd(xbus_pkg::REG_RDATA);
    chk("sync read", TXW, st);
    chk("straps held", 4'hF, cfg);
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
